// file: pkg/rbic_pkg.sv
// Constants shared by the remote bus interface control block.
// Assumes a single 20 MHz core clock and byte-wide bus transceiver logic.
package rbic_pkg;
  // ==========================================
  // Clock and serial rates
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int DIV_W = 16;
  localparam logic [1:0] BSEL_9600 = 2'h0;
  localparam logic [1:0] BSEL_19200 = 2'h1;
  localparam logic [1:0] BSEL_38400 = 2'h2;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;

  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SERVICE_REQUEST_ENABLE_MASK = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // CONFIG fields
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_RXT_BIT = 5;
  localparam int CFG_TXT_LSB = 6;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // MODE fields
  localparam int MODE_BSEL_LSB = 0;
  localparam int MODE_DNLD_BIT = 2;
  localparam logic [1:0] BSEL_RESET = 2'h2;

  // STATUS fields
  localparam int ST_SERIAL_BIT = 0;
  localparam int ST_LISTEN_BIT = 1;
  localparam int ST_TALK_BIT = 2;
  localparam int ST_SRQ_BIT = 3;
  localparam int ST_DNLD_BIT = 4;
  localparam int ST_LLO_BIT = 5;
  localparam int ST_TREQ_BIT = 6;

  // ==========================================
  // Characters
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SHIFT_IN = 8'h0f;
  localparam logic [7:0] CH_SHIFT_OUT = 8'h0e;
  localparam logic [7:0] CH_TALK_REQ = 8'h12;

  typedef enum logic [1:0] {
    RBIC_TXT_LF = 2'h0,
    RBIC_TXT_CR = 2'h1,
    RBIC_TXT_CRLF = 2'h2,
    RBIC_TXT_NONE = 2'h3
  } rbic_txterm_type;

  // ==========================================
  // Parallel bus commands (sent with attention)
  localparam logic [7:0] CMD_LISTEN_BASE = 8'h20;
  localparam logic [7:0] CMD_TALK_BASE = 8'h40;
  localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
  localparam logic [7:0] CMD_UNTALK = 8'h5f;
  localparam logic [7:0] CMD_SPOLL_EN = 8'h18;
  localparam logic [7:0] CMD_SPOLL_DIS = 8'h19;
  localparam logic [7:0] CMD_LOCKOUT = 8'h11;
  localparam logic [7:0] CMD_TRIGGER = 8'h08;
  localparam int RQS_BIT = 6;
endpackage

// file: rtl/rbic_uart.sv
// Asynchronous serial transmitter and receiver, 8 data bits, 1 stop bit.
// Assumes the caller supplies the bit period in clock cycles.
`timescale 1ns/1ns
module rbic_uart #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] div,
  input wire logic rx_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic tx_pin
);
  logic rx_s1_q, rx_s2_q, rx_busy_q;
  logic [DIV_W-1:0] rx_tmr_q, tx_tmr_q;
  logic [3:0] rx_bit_q, tx_cnt_q;
  logic [9:0] tx_sh_q;

  // ==========================================
  // Receive: center-sampled, LSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy_q <= 1'b0;
      rx_tmr_q <= '0;
      rx_bit_q <= 4'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_tmr_q <= div >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_tmr_q != '0) begin
        rx_tmr_q <= rx_tmr_q - 1'b1;
      end else begin
        rx_tmr_q <= div - 1'b1;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_s2_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_valid <= rx_s2_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_data <= {rx_s2_q, rx_data[7:1]};
        end
      end
    end
  end

  // ==========================================
  // Transmit: start, 8 data LSB first, stop
  assign tx_ready = (tx_cnt_q == 4'h0);
  assign tx_pin = tx_sh_q[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= 10'h3ff;
      tx_cnt_q <= 4'h0;
      tx_tmr_q <= '0;
    end else if (tx_cnt_q == 4'h0) begin
      if (tx_start) begin
        tx_sh_q <= {1'b1, tx_data, 1'b0};
        tx_cnt_q <= 4'ha;
        tx_tmr_q <= div - 1'b1;
      end
    end else if (tx_tmr_q != '0) begin
      tx_tmr_q <= tx_tmr_q - 1'b1;
    end else begin
      tx_tmr_q <= div - 1'b1;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_cnt_q <= tx_cnt_q - 4'h1;
    end
  end
endmodule

// file: rtl/rbic_top.sv
// Remote bus interface control: parallel bus addressing, string framing,
// service request and serial remote mode.
// Assumes a byte-level parallel bus transceiver on the same clock and a
// talk-buffer stream from the measurement side.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module rbic_top (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] PB_RX_DATA,
  input wire logic PB_RX_STB,
  input wire logic PB_RX_ATN,
  input wire logic PB_RX_EOI,
  output logic [7:0] PB_TX_DATA,
  output logic PB_TX_STB,
  output logic PB_TX_EOI,
  input wire logic PB_TX_READY,
  output logic SRQ_OUT,
  output logic TRIGGER_PULSE,
  input wire logic SER_RX,
  output logic SER_TX,
  output logic [7:0] CMD_DATA,
  output logic CMD_VALID,
  output logic CMD_END,
  input wire logic [7:0] TALK_DATA,
  input wire logic TALK_VALID,
  input wire logic TALK_LAST,
  output logic TALK_READY,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic NATIVE_MODE,
  input wire logic LOCAL_RETURN_KEY,
  output logic SERIAL_REMOTE_INDICATOR,
  output logic PANEL_LOCKED,
  output logic TALK_REFRESH
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DATA = 5'b00010,
    ST_TERM1 = 5'b00100,
    ST_TERM2 = 5'b01000,
    ST_POLL = 5'b10000
  } rbic_state_type;

  rbic_state_type state_q, state_d;
  logic [4:0] bus_addr_q;
  logic rx_term_cr_q;
  rbic_pkg::rbic_txterm_type tx_term_q;
  logic [7:0] service_request_enable_mask_q;
  logic [1:0] baud_sel_q;
  logic dnld_q, serial_q, listen_q, talk_q, spoll_q, poll_sent_q, llo_q, treq_q;
  logic [rbic_pkg::DIV_W-1:0] div;
  logic urx_valid, utx_ready;
  logic [7:0] urx_data;
  logic out_stb_q;
  logic [7:0] out_byte_q;
  logic sink_ready, issue, srq_live, talk_go;
  logic [7:0] next_byte, poll_byte;
  logic next_eoi;

  // ==========================================
  // Helpers
  function automatic logic [rbic_pkg::DIV_W-1:0] baud_div(input logic [1:0] sel);
    int rate;
    rate = rbic_pkg::BAUD_38400;
    if (sel == rbic_pkg::BSEL_9600) rate = rbic_pkg::BAUD_9600;
    if (sel == rbic_pkg::BSEL_19200) rate = rbic_pkg::BAUD_19200;
    baud_div = rbic_pkg::DIV_W'((rbic_pkg::CLK_HZ + rate / 2) / rate);
  endfunction

  function automatic logic is_rx_term(input logic [7:0] b, input logic cr_sel);
    is_rx_term = (b == (cr_sel ? rbic_pkg::CH_CR : rbic_pkg::CH_LF));
  endfunction

  // ==========================================
  // Register writes
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_addr_q <= rbic_pkg::CFG_RESET[rbic_pkg::CFG_ADDR_LSB +: 5];
      rx_term_cr_q <= rbic_pkg::CFG_RESET[rbic_pkg::CFG_RXT_BIT];
      tx_term_q <= rbic_pkg::rbic_txterm_type'(rbic_pkg::CFG_RESET[rbic_pkg::CFG_TXT_LSB +: 2]);
    end else if (WR && ADDR == rbic_pkg::REG_CONFIG) begin
      if (WDATA[rbic_pkg::CFG_ADDR_LSB +: 5] <= rbic_pkg::ADDR_MAX) begin
        bus_addr_q <= WDATA[rbic_pkg::CFG_ADDR_LSB +: 5];
      end
      rx_term_cr_q <= WDATA[rbic_pkg::CFG_RXT_BIT];
      tx_term_q <= rbic_pkg::rbic_txterm_type'(WDATA[rbic_pkg::CFG_TXT_LSB +: 2]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      service_request_enable_mask_q <= rbic_pkg::MASK_RESET;
    end else if (WR && ADDR == rbic_pkg::REG_SERVICE_REQUEST_ENABLE_MASK) begin
      service_request_enable_mask_q <= WDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      baud_sel_q <= rbic_pkg::BSEL_RESET;
      dnld_q <= 1'b0;
    end else if (WR && ADDR == rbic_pkg::REG_MODE) begin
      baud_sel_q <= WDATA[rbic_pkg::MODE_BSEL_LSB +: 2];
      if (WDATA[rbic_pkg::MODE_DNLD_BIT]) begin
        dnld_q <= 1'b1;
        baud_sel_q <= rbic_pkg::BSEL_38400;
      end
    end
  end

  // ==========================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= 32'h0000_0000;
      if (RD) begin
        unique case (ADDR)
          rbic_pkg::REG_CONFIG: begin
            RDATA[rbic_pkg::CFG_ADDR_LSB +: 5] <= bus_addr_q;
            RDATA[rbic_pkg::CFG_RXT_BIT] <= rx_term_cr_q;
            RDATA[rbic_pkg::CFG_TXT_LSB +: 2] <= tx_term_q;
          end
          rbic_pkg::REG_SERVICE_REQUEST_ENABLE_MASK: begin
            RDATA[7:0] <= service_request_enable_mask_q;
          end
          rbic_pkg::REG_MODE: begin
            RDATA[rbic_pkg::MODE_BSEL_LSB +: 2] <= baud_sel_q;
            RDATA[rbic_pkg::MODE_DNLD_BIT] <= dnld_q;
          end
          rbic_pkg::REG_STATUS: begin
            RDATA[rbic_pkg::ST_SERIAL_BIT] <= serial_q;
            RDATA[rbic_pkg::ST_LISTEN_BIT] <= listen_q;
            RDATA[rbic_pkg::ST_TALK_BIT] <= talk_q;
            RDATA[rbic_pkg::ST_SRQ_BIT] <= SRQ_OUT;
            RDATA[rbic_pkg::ST_DNLD_BIT] <= dnld_q;
            RDATA[rbic_pkg::ST_LLO_BIT] <= llo_q;
            RDATA[rbic_pkg::ST_TREQ_BIT] <= treq_q;
          end
          default: begin
            RDATA <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Serial port
  // Downloader always runs 38400 8N1 with no handshake
  assign div = dnld_q ? baud_div(rbic_pkg::BSEL_38400) : baud_div(baud_sel_q);

  rbic_uart #(
    .DIV_W(rbic_pkg::DIV_W)
  ) u_uart (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .div(div),
    .rx_pin(SER_RX),
    .rx_valid(urx_valid),
    .rx_data(urx_data),
    .tx_start(out_stb_q && serial_q),
    .tx_data(out_byte_q),
    .tx_ready(utx_ready),
    .tx_pin(SER_TX)
  );

  // ==========================================
  // Serial remote mode
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      serial_q <= 1'b0;
    end else if (urx_valid && urx_data == rbic_pkg::CH_SHIFT_IN) begin
      serial_q <= 1'b1;
    end else if (urx_valid && urx_data == rbic_pkg::CH_SHIFT_OUT) begin
      serial_q <= 1'b0;
    end else if (LOCAL_RETURN_KEY) begin
      serial_q <= 1'b0;
    end
  end

  // Talk request is held until one string and its terminator are sent
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      treq_q <= 1'b0;
    end else if (serial_q && urx_valid && urx_data == rbic_pkg::CH_TALK_REQ) begin
      treq_q <= 1'b1;
    end else if (!serial_q || (issue && state_d == ST_IDLE && state_q != ST_POLL)) begin
      treq_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SERIAL_REMOTE_INDICATOR <= 1'b0;
      PANEL_LOCKED <= 1'b0;
      TALK_REFRESH <= 1'b0;
    end else begin
      SERIAL_REMOTE_INDICATOR <= serial_q;
      PANEL_LOCKED <= serial_q;
      TALK_REFRESH <= serial_q && NATIVE_MODE;
    end
  end

  // ==========================================
  // Parallel bus addressing and bus commands
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      spoll_q <= 1'b0;
      llo_q <= 1'b0;
    end else if (serial_q) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
      spoll_q <= 1'b0;
    end else if (PB_RX_STB && PB_RX_ATN) begin
      if (PB_RX_DATA == (rbic_pkg::CMD_LISTEN_BASE | {3'h0, bus_addr_q})) begin
        listen_q <= 1'b1;
      end else if (PB_RX_DATA == rbic_pkg::CMD_UNLISTEN) begin
        listen_q <= 1'b0;
      end
      if (PB_RX_DATA == (rbic_pkg::CMD_TALK_BASE | {3'h0, bus_addr_q})) begin
        talk_q <= 1'b1;
      end else if (PB_RX_DATA == rbic_pkg::CMD_UNTALK ||
                   (PB_RX_DATA[7:5] == rbic_pkg::CMD_TALK_BASE[7:5])) begin
        talk_q <= 1'b0;
      end
      if (PB_RX_DATA == rbic_pkg::CMD_SPOLL_EN) begin
        spoll_q <= 1'b1;
      end else if (PB_RX_DATA == rbic_pkg::CMD_SPOLL_DIS) begin
        spoll_q <= 1'b0;
      end
      if (PB_RX_DATA == rbic_pkg::CMD_LOCKOUT) begin
        llo_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      TRIGGER_PULSE <= 1'b0;
    end else begin
      TRIGGER_PULSE <= !serial_q && listen_q && PB_RX_STB && PB_RX_ATN &&
                       PB_RX_DATA == rbic_pkg::CMD_TRIGGER;
    end
  end

  // Poll answer goes once per enable
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      poll_sent_q <= 1'b0;
    end else if (!spoll_q) begin
      poll_sent_q <= 1'b0;
    end else if (issue && state_q == ST_POLL) begin
      poll_sent_q <= 1'b1;
    end
  end

  // ==========================================
  // Service request
  assign srq_live = |(STATUS_BYTE & service_request_enable_mask_q);
  assign poll_byte = {STATUS_BYTE[7], srq_live, STATUS_BYTE[5:0]};

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SRQ_OUT <= 1'b0;
    end else begin
      SRQ_OUT <= srq_live && !serial_q;
    end
  end

  // ==========================================
  // Incoming command characters
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_DATA <= 8'h00;
      CMD_VALID <= 1'b0;
      CMD_END <= 1'b0;
    end else begin
      CMD_VALID <= 1'b0;
      CMD_END <= 1'b0;
      if (serial_q && urx_valid && urx_data != rbic_pkg::CH_SHIFT_IN &&
          urx_data != rbic_pkg::CH_SHIFT_OUT && urx_data != rbic_pkg::CH_TALK_REQ) begin
        CMD_DATA <= urx_data;
        CMD_VALID <= 1'b1;
        CMD_END <= is_rx_term(urx_data, rx_term_cr_q);
      end else if (!serial_q && listen_q && PB_RX_STB && !PB_RX_ATN) begin
        CMD_DATA <= PB_RX_DATA;
        CMD_VALID <= 1'b1;
        CMD_END <= PB_RX_EOI || is_rx_term(PB_RX_DATA, rx_term_cr_q);
      end
    end
  end

  // ==========================================
  // Outgoing strings
  assign sink_ready = serial_q ? utx_ready : PB_TX_READY;
  assign issue = (state_q != ST_IDLE) && sink_ready && !out_stb_q;
  assign talk_go = serial_q ? treq_q : talk_q;
  assign TALK_READY = issue && state_q == ST_DATA;

  always_comb begin
    state_d = state_q;
    next_byte = TALK_DATA;
    next_eoi = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (!serial_q && talk_q && spoll_q && !poll_sent_q) begin
          state_d = ST_POLL;
        end else if (talk_go && !spoll_q && TALK_VALID) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        next_eoi = TALK_LAST && tx_term_q == rbic_pkg::RBIC_TXT_NONE;
        if (!TALK_VALID) begin
          state_d = ST_DATA;
        end else if (issue && TALK_LAST) begin
          state_d = (tx_term_q == rbic_pkg::RBIC_TXT_NONE) ? ST_IDLE : ST_TERM1;
        end
      end
      ST_TERM1: begin
        next_byte = (tx_term_q == rbic_pkg::RBIC_TXT_LF) ? rbic_pkg::CH_LF : rbic_pkg::CH_CR;
        next_eoi = tx_term_q != rbic_pkg::RBIC_TXT_CRLF;
        if (issue) begin
          state_d = (tx_term_q == rbic_pkg::RBIC_TXT_CRLF) ? ST_TERM2 : ST_IDLE;
        end
      end
      ST_TERM2: begin
        next_byte = rbic_pkg::CH_LF;
        next_eoi = 1'b1;
        if (issue) begin
          state_d = ST_IDLE;
        end
      end
      ST_POLL: begin
        next_byte = poll_byte;
        next_eoi = 1'b0;
        if (issue) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
    end else if (state_q == ST_DATA && !TALK_VALID && !talk_go) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_stb_q <= 1'b0;
      out_byte_q <= 8'h00;
      PB_TX_EOI <= 1'b0;
    end else begin
      out_stb_q <= issue && (state_q != ST_DATA || TALK_VALID);
      if (issue) begin
        out_byte_q <= next_byte;
        PB_TX_EOI <= next_eoi && !serial_q;
      end
    end
  end

  assign PB_TX_STB = out_stb_q && !serial_q;
  assign PB_TX_DATA = out_byte_q;
endmodule

// file: sim/rbic_top_assertions.sv
// Port-level checker for the remote bus interface control block.
// Assumes it is bound to rbic_top and sees only that module's ports.
`timescale 1ns/1ns
module rbic_top_assertions (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic PB_TX_STB,
  input wire logic PB_TX_READY,
  input wire logic SRQ_OUT,
  input wire logic TRIGGER_PULSE,
  input wire logic LOCAL_RETURN_KEY,
  input wire logic SERIAL_REMOTE_INDICATOR,
  input wire logic PANEL_LOCKED,
  input wire logic TALK_REFRESH
);
  // ==========================================
  // Mask shadow
  logic mask_zero_q;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mask_zero_q <= 1'b1;
    end else if (WR && ADDR == rbic_pkg::REG_SERVICE_REQUEST_ENABLE_MASK) begin
      mask_zero_q <= WDATA[7:0] == 8'h00;
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence serial_held_s;
    SERIAL_REMOTE_INDICATOR ##1 SERIAL_REMOTE_INDICATOR;
  endsequence
  sequence key_in_serial_s;
    SERIAL_REMOTE_INDICATOR && LOCAL_RETURN_KEY;
  endsequence
  srq_masked_a: assert property (
    mask_zero_q && $past(mask_zero_q) |-> !SRQ_OUT) else $error("service request with zero mask");
  srq_serial_a: assert property (
    serial_held_s |-> !SRQ_OUT) else $error("service request in serial mode");
  trig_serial_a: assert property (
    TRIGGER_PULSE |-> !SERIAL_REMOTE_INDICATOR ##1 !TRIGGER_PULSE) else $error("bad trigger");
  panel_lock_a: assert property (
    PANEL_LOCKED == SERIAL_REMOTE_INDICATOR) else $error("panel lock differs from mode");
  key_local_a: assert property (
    key_in_serial_s |-> ##[1:3] !SERIAL_REMOTE_INDICATOR) else $error("key did not leave serial");
  refresh_mode_a: assert property (
    TALK_REFRESH |-> SERIAL_REMOTE_INDICATOR || $past(SERIAL_REMOTE_INDICATOR))
    else $error("refresh outside serial mode");
  tx_gap_a: assert property (
    PB_TX_STB |=> !PB_TX_STB) else $error("transmit strobes too close");
  tx_ready_a: assert property (
    PB_TX_STB |-> $past(PB_TX_READY)) else $error("byte sent while transceiver busy");
endmodule

bind rbic_top rbic_top_assertions u_rbic_top_assertions (.CORE_CLK, .RESETN, .ADDR, .WDATA,
  .WR, .PB_TX_STB, .PB_TX_READY, .SRQ_OUT, .TRIGGER_PULSE, .LOCAL_RETURN_KEY,
  .SERIAL_REMOTE_INDICATOR, .PANEL_LOCKED, .TALK_REFRESH);

// file: sim/rbic_host_model.sv
// Host terminal on the serial line: sends and receives 8N1 characters.
// Assumes the bit period in core clock cycles is given by BIT.
`timescale 1ns/1ns
module rbic_host_model #(
  parameter int BIT = 521
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line,
  output logic [7:0] got,
  output logic got_stb
);
  // ==========================================
  // Sender and receiver
  initial begin
    rx_line = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // A bad stop bit drops the character, so its expectation stays unmet
  always begin
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] <= tx_line;
    end
    repeat (BIT) @(posedge clk);
    got_stb <= tx_line;
    @(posedge clk);
    got_stb <= 1'b0;
  end
endmodule

// file: sim/rbic_top_tb_top.sv
// Self-checking bench for the remote bus interface control block.
// Assumes a 20 MHz core clock and a host terminal at 38400 baud.
`timescale 1ns/1ns
module rbic_top_tb_top;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] ADDR = 8'h00, PB_RX_DATA = 8'h00, TALK_DATA = 8'h00, STATUS_BYTE = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0, RD = 1'b0, PB_RX_STB = 1'b0, PB_RX_ATN = 1'b0, PB_RX_EOI = 1'b0;
  logic TALK_VALID = 1'b0, TALK_LAST = 1'b0, NATIVE_MODE = 1'b0;
  logic LOCAL_RETURN_KEY = 1'b0, PB_TX_READY = 1'b1;
  logic [31:0] RDATA;
  logic [7:0] PB_TX_DATA, CMD_DATA, host_byte;
  logic PB_TX_STB, PB_TX_EOI, SRQ_OUT, TRIGGER_PULSE, SER_RX, SER_TX, CMD_VALID, CMD_END;
  logic TALK_READY, SERIAL_REMOTE_INDICATOR, PANEL_LOCKED, TALK_REFRESH, host_stb;
  logic rd_seen = 1'b0;
  logic [8:0] qc[$], qp[$], qs[$];
  logic [31:0] qr[$];
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] d;

  rbic_top u_rbic_top (.*);
  rbic_host_model u_rbic_host_model (.clk(CORE_CLK), .tx_line(SER_TX), .rx_line(SER_RX),
    .got(host_byte), .got_stb(host_stb));

  always #25 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) PB_TX_READY <= !PB_TX_STB && ($urandom % 4 != 0);
  always @(posedge CORE_CLK) rd_seen <= RD;

  // ==========================================
  // Comparison and monitor
  task cmp_word(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cmp_byte(input logic [8:0] e, input logic [8:0] g);
    cmp_word({23'h0, e}, {23'h0, g});
  endtask
  always @(negedge CORE_CLK) begin
    if (CMD_VALID === 1'b1) cmp_byte(qc.size() ? qc.pop_front() : 9'h1ff, {CMD_END, CMD_DATA});
    if (PB_TX_STB === 1'b1) cmp_byte(qp.size() ? qp.pop_front() : 9'h1ff, {PB_TX_EOI, PB_TX_DATA});
    if (host_stb === 1'b1) cmp_byte(qs.size() ? qs.pop_front() : 9'h1ff, {1'b0, host_byte});
    if (rd_seen) cmp_word(qr.pop_front(), RDATA);
  end

  // ==========================================
  // Drivers
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    qr.push_back(e);
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 1'b0;
  endtask
  task pb(input logic [7:0] b, input logic atn, eoi, input logic [1:0] e);
    if (e[1]) qc.push_back({e[0], b});
    @(posedge CORE_CLK);
    PB_RX_STB <= 1'b1;
    PB_RX_DATA <= b;
    PB_RX_ATN <= atn;
    PB_RX_EOI <= eoi;
    @(posedge CORE_CLK);
    PB_RX_STB <= 1'b0;
  endtask
  task tk(input logic [7:0] b);
    @(posedge CORE_CLK);
    TALK_VALID <= 1'b1;
    TALK_DATA <= b;
    TALK_LAST <= 1'b1;
    do @(negedge CORE_CLK); while (TALK_READY !== 1'b1);
    @(posedge CORE_CLK);
    TALK_VALID <= 1'b0;
  endtask
  task automatic exp_str(input bit serial_remote_indicator, input logic [1:0] tt, input logic [7:0] b);
    logic [7:0] s[$];
    s = {b};
    if (tt == 2'h1 || tt == 2'h2) s.push_back(rbic_pkg::CH_CR);
    if (tt == 2'h0 || tt == 2'h2) s.push_back(rbic_pkg::CH_LF);
    foreach (s[i]) begin
      if (serial_remote_indicator) qs.push_back({1'b0, s[i]});
      else qp.push_back({i == s.size() - 1, s[i]});
    end
  endtask
  task drain;
    while (qp.size() + qs.size() != 0) @(negedge CORE_CLK);
  endtask
  task send(input logic [7:0] b);
    u_rbic_host_model.send(b);
    repeat (8) @(posedge CORE_CLK);
  endtask
  function logic [7:0] rnd;
    return 8'h40 | 8'($urandom % 32);
  endfunction
  task summarize;
    if (qc.size() + qp.size() + qs.size() + qr.size() != 0) begin
      miscompares++;
      $display("mismatch at %0t: expected results never seen", $time);
    end
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    #(100000 * 50);
    miscompares++;
    summarize;
  end
  initial begin
    void'($urandom(32'hb3d1));
    repeat (16) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(rbic_pkg::REG_CONFIG, 32'h0);
    rd(rbic_pkg::REG_SERVICE_REQUEST_ENABLE_MASK, 32'h0);
    rd(rbic_pkg::REG_MODE, 32'h2);
    rd(8'h10, 32'h0);
    wr(rbic_pkg::REG_CONFIG, 32'h85);
    wr(rbic_pkg::REG_CONFIG, 32'h9f);
    rd(rbic_pkg::REG_CONFIG, 32'h85);
    STATUS_BYTE <= 8'h01 | 8'($urandom);
    repeat (4) @(negedge CORE_CLK);
    cmp_word(32'h0, {31'h0, SRQ_OUT});
    wr(rbic_pkg::REG_SERVICE_REQUEST_ENABLE_MASK, 32'hff);
    repeat (3) @(negedge CORE_CLK);
    cmp_word(32'h1, {31'h0, SRQ_OUT});
    pb(8'h26, 1'b1, 1'b0, 2'h0);
    pb(8'h41, 1'b0, 1'b0, 2'h0);
    pb(8'h25, 1'b1, 1'b0, 2'h0);
    d = rnd();
    pb(d, 1'b0, 1'b0, 2'h2);
    pb(rbic_pkg::CH_LF, 1'b0, 1'b0, 2'h3);
    pb(d, 1'b0, 1'b1, 2'h3);
    wr(rbic_pkg::REG_CONFIG, 32'ha5);
    pb(rbic_pkg::CH_CR, 1'b0, 1'b0, 2'h3);
    pb(rbic_pkg::CH_LF, 1'b0, 1'b0, 2'h2);
    pb(rbic_pkg::CMD_TRIGGER, 1'b1, 1'b0, 2'h0);
    @(negedge CORE_CLK);
    cmp_word(32'h1, {31'h0, TRIGGER_PULSE});
    for (int t = 0; t < 4; t++) begin
      wr(rbic_pkg::REG_CONFIG, {24'h0, 2'(t), 6'h05});
      d = rnd();
      exp_str(1'b0, 2'(t), d);
      pb(8'h45, 1'b1, 1'b0, 2'h0);
      tk(d);
      drain;
      pb(rbic_pkg::CMD_UNTALK, 1'b1, 1'b0, 2'h0);
    end
    pb(rbic_pkg::CMD_SPOLL_EN, 1'b1, 1'b0, 2'h0);
    qp.push_back({1'b0, STATUS_BYTE | 8'h40});
    pb(8'h45, 1'b1, 1'b0, 2'h0);
    drain;
    pb(rbic_pkg::CMD_SPOLL_DIS, 1'b1, 1'b0, 2'h0);
    pb(rbic_pkg::CMD_UNTALK, 1'b1, 1'b0, 2'h0);
    wr(rbic_pkg::REG_CONFIG, 32'h85);
    NATIVE_MODE <= 1'b1;
    send(rbic_pkg::CH_SHIFT_IN);
    cmp_word(32'h7, {29'h0, SERIAL_REMOTE_INDICATOR, PANEL_LOCKED, TALK_REFRESH});
    cmp_word(32'h0, {31'h0, SRQ_OUT});
    pb(8'h25, 1'b1, 1'b0, 2'h0);
    pb(8'h41, 1'b0, 1'b0, 2'h0);
    pb(rbic_pkg::CMD_TRIGGER, 1'b1, 1'b0, 2'h0);
    pb(rbic_pkg::CMD_LOCKOUT, 1'b1, 1'b0, 2'h0);
    d = rnd();
    qc.push_back({1'b0, d});
    send(d);
    qc.push_back({1'b1, rbic_pkg::CH_LF});
    send(rbic_pkg::CH_LF);
    d = rnd();
    exp_str(1'b1, 2'h2, d);
    send(rbic_pkg::CH_TALK_REQ);
    tk(d);
    drain;
    d = rnd();
    fork
      tk(d);
    join_none
    repeat (6000) @(negedge CORE_CLK);
    exp_str(1'b1, 2'h2, d);
    send(rbic_pkg::CH_TALK_REQ);
    drain;
    @(posedge CORE_CLK);
    LOCAL_RETURN_KEY <= 1'b1;
    @(posedge CORE_CLK);
    LOCAL_RETURN_KEY <= 1'b0;
    repeat (4) @(negedge CORE_CLK);
    cmp_word(32'h0, {31'h0, SERIAL_REMOTE_INDICATOR});
    send(rbic_pkg::CH_SHIFT_IN);
    cmp_word(32'h1, {31'h0, SERIAL_REMOTE_INDICATOR});
    send(rbic_pkg::CH_SHIFT_OUT);
    cmp_word(32'h0, {31'h0, SERIAL_REMOTE_INDICATOR});
    STATUS_BYTE <= 8'h00;
    wr(rbic_pkg::REG_MODE, 32'h1);
    rd(rbic_pkg::REG_MODE, 32'h1);
    wr(rbic_pkg::REG_MODE, 32'h4);
    rd(rbic_pkg::REG_STATUS, 32'h10);
    rd(rbic_pkg::REG_MODE, 32'h6);
    repeat (4) @(posedge CORE_CLK);
    summarize;
  end
endmodule
